// *** rtl/iesr_pkg.sv ***
// Package for the interrupt enable/status register block.
// Assumes a single core clock domain; register offsets are byte addresses.
package iesr_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [9:0] OFS_IDENT = 10'h0C0;
  localparam logic [9:0] OFS_INT_EN = 10'h0C4;
  localparam logic [9:0] OFS_INT_ST = 10'h0C8;
  // ==========================================================================
  // Field positions
  localparam int BIT_SOFT = 15;
  localparam int BIT_MFLT = 13;
  localparam int BIT_TFLT = 12;
  localparam int BIT_PIN_HI = 6;
  localparam int BIT_PIN_LO = 4;
  localparam int BIT_TMR = 3;
  localparam int BIT_XCVR = 2;
  localparam int BIT_WAKE = 1;
  localparam int BIT_DMA = 0;
  localparam int NUM_PINS = 3;
  // ==========================================================================
  // Reset values and writable masks
  localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
  localparam logic [31:0] RST_STATUS = 32'h0000_0000;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;
  localparam logic        RST_REQUEST = 1'b0;
  localparam logic [31:0] MASK_ENABLE = 32'h0000_B07E;
  localparam logic [31:0] MASK_W1C = 32'h0000_B078;
  // Identification values, arbitrary
  localparam logic [15:0] MODEL_ID = 16'h5A5A;
  localparam logic [15:0] BLOCK_REV = 16'h0001;
endpackage : iesr_pkg

// *** rtl/iesr_sync.sv ***
// Two-flop synchroniser for one level input.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
module iesr_sync
(
  input  wire logic clk,     // Core clock
  input  wire logic rst,     // Async reset, active high
  input  wire logic d,       // Asynchronous level
  output logic      q        // Synchronised level
);
  logic meta_reg;
  logic meta_next;
  logic q_next;

  always_comb
  begin
    meta_next = d;
    q_next    = meta_reg;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= 1'b0;
      q        <= 1'b0;
    end
    else
    begin
      meta_reg <= meta_next;
      q        <= q_next;
    end
  end
endmodule : iesr_sync

// *** rtl/iesr_top.sv ***
// Interrupt enable, interrupt status and identification registers.
// Assumes a same-clock register port from the target interface and
// same-clock single-cycle event pulses; level sources from other blocks
// arrive asynchronously and are synchronised here.
// Function
// R01: A rising edge of the software trigger enable sets the software flag.
// R02: Writing one to the software flag clears it; zero leaves it.
// R03: A DMA read fault sets the master fault flag, cleared by writing one.
// R04: Software recovers from a bus fault with a soft or hardware reset.
// R05: A target access fault sets the target fault flag, cleared by writing one.
// R06: Three pin event flags, each cleared by writing one to itself.
// R07: A timer wrap sets the timer flag, cleared by writing one.
// R08: The transceiver flag mirrors the transceiver line and ignores writes.
// R09: The fault flags reach the request only while their enables are set.
// R10: Pin, timer, transceiver and wake enables gate their sources.
// R11: The DMA source is gated by the DMA enable from the DMA block.
// R12: The identification register holds model id and block revision.
// R13: Registers sit at byte offsets C0h, C4h and C8h.
// R14: The wake flag mirrors the wake sources and ignores writes.
// R15: The DMA flag mirrors the DMA source and ignores writes.
// R16: Request is the OR of enabled flags and the software flag; all reset to zero.
`timescale 1ns/1ps
module iesr_top
(
  input  wire logic        core_clk,           // 10 MHz core clock
  input  wire logic        rst,                // Async reset, active high
  input  wire logic        reg_wr,             // Register write strobe
  input  wire logic        reg_rd,             // Register read strobe
  input  wire logic [9:0]  reg_addr,           // Register byte address
  input  wire logic [31:0] reg_wdata,          // Write data
  output logic      [31:0] reg_rdata,          // Read data, valid cycle after reg_rd
  input  wire logic        master_fault_evt,   // DMA read fault pulse
  input  wire logic        target_fault_evt,   // Target access fault pulse
  input  wire logic [2:0]  pin_event_evt,      // Pin event pulses
  input  wire logic        timer_wrap_evt,     // Timer wrap pulse
  input  wire logic        transceiver_irq,    // Transceiver line, async
  input  wire logic        wake_src,           // Any wake source set, async
  input  wire logic        dma_irq,            // DMA source flag, async
  input  wire logic        dma_irq_enable,     // DMA enable from DMA registers
  output logic [31:0]      interrupt_enable,   // Enable register image
  output logic             irq_request         // Combined request
);
  // ==========================================================================
  // Synchronisers
  // Only the second flop of each pair is read by logic
  logic transceiver_s;
  logic wake_s;
  logic dma_s;

  iesr_sync u_sync_xcvr
  (
    .clk (core_clk),
    .rst (rst),
    .d   (transceiver_irq),
    .q   (transceiver_s)
  );

  iesr_sync u_sync_wake
  (
    .clk (core_clk),
    .rst (rst),
    .d   (wake_src),
    .q   (wake_s)
  );

  iesr_sync u_sync_dma
  (
    .clk (core_clk),
    .rst (rst),
    .d   (dma_irq),
    .q   (dma_s)
  );

  // ==========================================================================
  // Address decode
  logic hit_ident;
  logic hit_enable;
  logic hit_status;
  logic wr_enable;
  logic wr_status;

  always_comb
  begin
    hit_ident  = (reg_addr == iesr_pkg::OFS_IDENT);  // R13
    hit_enable = (reg_addr == iesr_pkg::OFS_INT_EN); // R13
    hit_status = (reg_addr == iesr_pkg::OFS_INT_ST); // R13
    wr_enable  = reg_wr && hit_enable;
    wr_status  = reg_wr && hit_status;
  end

  // ==========================================================================
  // Enable register
  logic [31:0] enable_reg;
  logic [31:0] enable_next;

  always_comb
  begin
    enable_next = enable_reg;
    if (wr_enable)
    begin
      enable_next = reg_wdata & iesr_pkg::MASK_ENABLE; // R10 R16
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      enable_reg <= iesr_pkg::RST_ENABLE; // R16
    end
    else
    begin
      enable_reg <= enable_next;
    end
  end

  // Image leaves straight from the register
  assign interrupt_enable = enable_reg;

  // ==========================================================================
  // Event sources
  logic        soft_rise;
  logic [31:0] set_bits;
  logic [31:0] clr_bits;

  always_comb
  begin
    // Edge of the register itself, so a held one cannot re-trigger
    soft_rise = enable_next[iesr_pkg::BIT_SOFT] && !enable_reg[iesr_pkg::BIT_SOFT]; // R01
    set_bits = 32'h0000_0000;
    set_bits[iesr_pkg::BIT_SOFT] = soft_rise; // R01
    set_bits[iesr_pkg::BIT_MFLT] = master_fault_evt; // R03
    set_bits[iesr_pkg::BIT_TFLT] = target_fault_evt; // R05
    set_bits[iesr_pkg::BIT_PIN_HI:iesr_pkg::BIT_PIN_LO] = pin_event_evt; // R06
    set_bits[iesr_pkg::BIT_TMR] = timer_wrap_evt; // R07
    clr_bits = 32'h0000_0000;
    if (wr_status)
    begin
      clr_bits = reg_wdata & iesr_pkg::MASK_W1C; // R02 R03 R05 R06 R07
    end
  end

  // ==========================================================================
  // Latched status
  logic [31:0] latched_reg;
  logic [31:0] latched_next;

  always_comb
  begin
    // Same-cycle event beats a clear, so no event is lost
    latched_next = ((latched_reg & ~clr_bits) | set_bits) & iesr_pkg::MASK_W1C;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      latched_reg <= iesr_pkg::RST_STATUS; // R16
    end
    else
    begin
      latched_reg <= latched_next;
    end
  end

  // ==========================================================================
  // Status image
  // Mirrored bits follow their sources and ignore writes
  logic [31:0] status_view;

  always_comb
  begin
    status_view = latched_reg;
    status_view[iesr_pkg::BIT_XCVR] = transceiver_s; // R08
    status_view[iesr_pkg::BIT_WAKE] = wake_s; // R14
    status_view[iesr_pkg::BIT_DMA] = dma_s; // R15
  end

  // ==========================================================================
  // Read-back
  // Read data holds until the next read
  logic [31:0] rdata_next;

  always_comb
  begin
    rdata_next = reg_rdata;
    if (reg_rd)
    begin
      unique case (reg_addr)
        iesr_pkg::OFS_IDENT:  rdata_next = {iesr_pkg::MODEL_ID, iesr_pkg::BLOCK_REV}; // R12
        iesr_pkg::OFS_INT_EN: rdata_next = enable_reg;
        iesr_pkg::OFS_INT_ST: rdata_next = status_view;
        default:              rdata_next = 32'h0000_0000; // R13
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= iesr_pkg::RST_RDATA;
    end
    else
    begin
      reg_rdata <= rdata_next;
    end
  end

  // ==========================================================================
  // Request
  logic [31:0] gated_bits;
  logic        irq_next;

  always_comb
  begin
    gated_bits = status_view & enable_reg & iesr_pkg::MASK_ENABLE; // R09 R10 R16
    // Enable bit 15 is a trigger, not a gate; the flag always requests
    gated_bits[iesr_pkg::BIT_SOFT] = status_view[iesr_pkg::BIT_SOFT];
    // No DMA bit in the enable register; the DMA block gates it
    gated_bits[iesr_pkg::BIT_DMA] = status_view[iesr_pkg::BIT_DMA] && dma_irq_enable; // R11
    irq_next = |gated_bits; // R16
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_request <= iesr_pkg::RST_REQUEST; // R16
    end
    else
    begin
      irq_request <= irq_next;
    end
  end
endmodule : iesr_top

// *** tb/iesr_chk.sv ***
// Port checker for iesr_top.
// Assumes one clock domain; bound below.
`timescale 1ns/1ps
module iesr_chk
(
  input wire logic        core_clk,         // Clk
  input wire logic        rst,              // Rst
  input wire logic        reg_wr,           // Wr
  input wire logic        reg_rd,           // Rd
  input wire logic [9:0]  reg_addr,         // Addr
  input wire logic [31:0] reg_wdata,        // Din
  input wire logic [31:0] reg_rdata,        // Dout
  input wire logic [31:0] interrupt_enable, // En
  input wire logic        irq_request       // Irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire en_wr = reg_wr && reg_addr == 10'h0C4;
  sequence s_soft_up;
    en_wr && reg_wdata[15] && !interrupt_enable[15];
  endsequence
  a_soft_set: assert property (s_soft_up |=> ##1 irq_request) else $error("soft");
  a_en_write:
    assert property (en_wr |=> interrupt_enable == ($past(reg_wdata) & 32'h0000_B07E))
    else $error("en");
  a_en_hold: assert property (!en_wr |=> $stable(interrupt_enable)) else $error("hold");
  a_en_resv:
    assert property ((interrupt_enable & 32'hFFFF_4F81) == 32'h0) else $error("resv");
  a_en_read:
    assert property (reg_rd && reg_addr == 10'h0C4 |=> reg_rdata == $past(interrupt_enable))
    else $error("rd en");
  a_id_read:
    assert property (reg_rd && reg_addr == 10'h0C0 |=> reg_rdata == 32'h5A5A_0001)
    else $error("id");
  a_hole_read:
    assert property (reg_rd && reg_addr == 10'h0CC |=> reg_rdata == 32'h0) else $error("hole");
  a_rd_hold: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rd");
endmodule : iesr_chk
bind iesr_top iesr_chk u_iesr_chk (.core_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rdata, .interrupt_enable, .irq_request);

// *** tb/iesr_host.sv ***
// Host model: one register access per call.
// Assumes strobes are sampled at rising core_clk.
`timescale 1ns/1ps
module iesr_host
(
  input  wire logic        core_clk,  // Clk
  output logic             reg_wr,    // Wr
  output logic             reg_rd,    // Rd
  output logic      [9:0]  reg_addr,  // Addr
  output logic      [31:0] reg_wdata  // Din
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
    @(posedge core_clk);
    // Stale data inverted so a late sample shows
    {reg_wr, reg_rd, reg_wdata} <= {2'b00, ~d};
    #1;
  endtask : acc
endmodule : iesr_host

// *** tb/iesr_tb_top.sv ***
// Bench for iesr_top: register tests through the host model.
// Assumes one-cycle read latency.
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("unexpected %0t %h %h", $time, a, e); end end
module iesr_tb_top;
  logic        core_clk = 1'b0, rst = 1'b1, dma_irq_enable = 1'b0, reg_wr, reg_rd, irq_request;
  logic [5:0]  ev = 6'h00;
  logic [2:0]  lv = 3'h0;
  logic [9:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, interrupt_enable;
  int          bad_count = 0, n_checks = 0;
  always #50 core_clk = ~core_clk;
  iesr_top u_iesr_top (.core_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .master_fault_evt(ev[5]), .target_fault_evt(ev[4]), .pin_event_evt(ev[3:1]),
    .timer_wrap_evt(ev[0]), .transceiver_irq(lv[2]), .wake_src(lv[1]), .dma_irq(lv[0]),
    .dma_irq_enable, .interrupt_enable, .irq_request);
  iesr_host u_iesr_host (.core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  task automatic w(input logic [9:0] a, input logic [31:0] d);
    u_iesr_host.acc(1'b1, a, d);
  endtask : w
  task automatic rc(input logic [9:0] a, input logic [31:0] e);
    u_iesr_host.acc(1'b0, a, 32'h0);
    `CHK(reg_rdata, e)
  endtask : rc
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rc(10'h0C4, 32'h0);
    w(10'h0C4, 32'hFFFF_FFFF);
    rc(10'h0C4, 32'h0000_B07E);
    `CHK(interrupt_enable, 32'h0000_B07E)
    rc(10'h0C8, 32'h0000_8000);
    `CHK(irq_request, 1'b1)
    w(10'h0C8, 32'h0000_7FFF);
    rc(10'h0C8, 32'h0000_8000);
    w(10'h0C8, 32'h0000_8000);
    w(10'h0C4, 32'h0000_B07E);
    rc(10'h0C8, 32'h0);
    $display("soft test done");
    @(posedge core_clk) ev <= 6'h3F;
    @(posedge core_clk) ev <= 6'h00;
    rc(10'h0C8, 32'h0000_3078);
    `CHK(irq_request, 1'b1)
    w(10'h0C8, 32'h0000_0010);
    rc(10'h0C8, 32'h0000_3068);
    w(10'h0C8, 32'hFFFF_FFFF);
    w(10'h0C4, 32'h0000_B076);
    @(posedge core_clk) ev <= 6'h01;
    @(posedge core_clk) ev <= 6'h00;
    rc(10'h0C8, 32'h0000_0008);
    `CHK(irq_request, 1'b0)
    w(10'h0C8, 32'hFFFF_FFFF);
    w(10'h0C4, 32'h0000_9000);
    @(posedge core_clk) ev <= 6'h20;
    @(posedge core_clk) ev <= 6'h10;
    @(posedge core_clk) ev <= 6'h00;
    #1 `CHK(irq_request, 1'b0)
    @(posedge core_clk);
    #1 `CHK(irq_request, 1'b1)
    $display("event test done");
    @(posedge core_clk) lv <= 3'h7;
    repeat (4) @(posedge core_clk);
    w(10'h0C8, 32'hFFFF_FFFF);
    rc(10'h0C8, 32'h0000_0007);
    w(10'h0C4, 32'h0);
    rc(10'h0CC, 32'h0);
    `CHK(irq_request, 1'b0)
    @(posedge core_clk) dma_irq_enable <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 `CHK(irq_request, 1'b1)
    w(10'h0C0, 32'h0);
    rc(10'h0C0, {iesr_pkg::MODEL_ID, iesr_pkg::BLOCK_REV});
    $display("level test done");
    @(posedge core_clk) lv <= 3'h0;
    repeat (3) @(posedge core_clk);
    rc(10'h0C8, 32'h0);
    w(10'h0C4, 32'h0000_B07E);
    @(posedge core_clk) rst <= 1'b1;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rc(10'h0C8, 32'h0);
    rc(10'h0C4, 32'h0);
    `CHK(interrupt_enable, 32'h0)
    `CHK(irq_request, 1'b0)
    $display("reset test done");
    end_sim;
  end
endmodule : iesr_tb_top
